// file: src/filter_loader_cfg.svh
// Purpose: constants for the address-filter table loader
// Assumes: 16-bit descriptor fields, sixteen table entries
// Notes: included by bare name
`ifndef FILTER_LOADER_CFG_SVH
`define FILTER_LOADER_CFG_SVH
`define FL_ENTRIES 16
`define FL_WORD_W 16
`define FL_PTR_W 4
`define FL_COUNT_W 5
`define FL_FIELDS_PER_DESC 3'd4
`define FL_STRIDE_32 16'h0004
`define FL_STRIDE_16 16'h0002
`define FL_MASK_RESET 16'h0000
`endif

// file: src/filter_loader_pkg.sv
// Purpose: types for the address-filter table loader
// Assumes: nothing
// Notes: states of the load sequencer
package filter_loader_pkg;
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_WAIT_IDLE,
    ST_REQ,
    ST_WAIT_ACK,
    ST_FINISH
  } load_state_t;
endpackage

// file: src/filter_table_mem.sv
// Purpose: sixteen 48-bit filter entries with an enable mask
// Assumes: writes come only from the loader sequencer
// Notes: read port gated by software reset
`include "filter_loader_cfg.svh"
module filter_table_mem #(
  parameter int ENTRIES = `FL_ENTRIES,
  parameter int PW = `FL_PTR_W
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic wrEn,
  input wire logic [PW-1:0] wrIdx,
  input wire logic [1:0] wrPort,
  input wire logic [15:0] wrData,
  input wire logic maskWrEn,
  input wire logic [15:0] maskData,
  input wire logic softReset,
  input wire logic [PW-1:0] rdIdx,
  output logic [47:0] rdEntry,
  output logic [ENTRIES-1:0] enableMask
);
  // --------------------------------
  // storage
  // --------------------------------
  logic [47:0] table_q [ENTRIES];
  always_ff @(posedge clk) begin
    if (wrEn) begin
      case (wrPort)
        2'h0: table_q[wrIdx][15:0] <= wrData; // RULE_15
        2'h1: table_q[wrIdx][31:16] <= wrData;
        2'h2: table_q[wrIdx][47:32] <= wrData;
        default: ;
      endcase
    end
  end
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      enableMask <= '0;
      rdEntry <= 48'h0;
    end else begin
      if (maskWrEn) begin
        enableMask <= maskData[ENTRIES-1:0]; // RULE_16
      end
      rdEntry <= softReset ? table_q[rdIdx] : 48'h0; // RULE_02
    end
  end
endmodule // filter_table_mem

// file: src/address_filter_table_loader.sv
// What this block does
// (RULE_01) table written only by the list load
// (RULE_02) table readable only during software reset
// (RULE_03) software keeps list in receive page
// (RULE_04) descriptors contiguous, four 16-bit fields each
// (RULE_05) 32-bit mode ignores upper data half
// (RULE_06) first field pointer, three filter words
// (RULE_07) trailing field loads entry enable mask
// (RULE_08) address is upper base plus pointer
// (RULE_09) only low five count bits used
// (RULE_10) software sets base, list, count, pointer
// (RULE_11) software rewrites pointer before each load
// (RULE_12) load waits for transmit and receive idle
// (RULE_13) ends past mask field, count zero
// (RULE_14) clears command and sets done flag
// (RULE_15) sixteen 48-bit entries, port 0 low
// (RULE_16) each entry disabled by mask bit
// (RULE_17) pointer steps per field, count per descriptor
//
// Purpose: fetch filter descriptors from memory and load the filter table
// Assumes: memory reads answer with memAck pulse and memRdData
// Notes: software writes pointer/count via load strobes
`include "filter_loader_cfg.svh"
module address_filter_table_loader #(
  parameter int ENTRIES = `FL_ENTRIES,
  parameter int PW = `FL_PTR_W
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic upper_resource_base_wr,
  input wire logic [15:0] upper_resource_base_in,
  input wire logic filter_list_pointer_wr,
  input wire logic [15:0] filter_list_pointer_in,
  input wire logic filter_list_count_wr,
  input wire logic [15:0] filter_list_count_in,
  input wire logic load_filter_table_cmd_set,
  input wire logic filter_load_done_flag_clr,
  input wire logic wideBus,
  input wire logic txBusy,
  input wire logic rxBusy,
  input wire logic softReset,
  input wire logic [PW-1:0] tableRdIdx,
  output logic memRdReq,
  output logic [31:0] memAddr,
  input wire logic memAck,
  input wire logic [31:0] memRdData,
  output logic load_filter_table_cmd,
  output logic filter_load_done_flag,
  output logic [15:0] filter_list_pointer,
  output logic [`FL_COUNT_W-1:0] filter_list_count,
  output logic [15:0] upper_resource_base,
  output logic [47:0] tableRdEntry,
  output logic [ENTRIES-1:0] entryEnableMask
);
  // --------------------------------
  // state
  // --------------------------------
  filter_loader_pkg::load_state_t state_q;
  filter_loader_pkg::load_state_t state_d;
  logic [2:0] field_q;
  logic [PW-1:0] entryPtr_q;
  logic lastField;
  logic [15:0] fieldData;
  logic [15:0] stride;
  logic fieldDone;
  logic isPtrField;
  logic isMaskField;
  logic tblWrEn;
  logic [1:0] tblPort;
  logic [15:0] ptrNext;
  logic [15:0] baseNext;

  // --------------------------------
  // decode
  // --------------------------------
  assign fieldData = memRdData[15:0]; // RULE_05
  assign stride = wideBus ? `FL_STRIDE_32 : `FL_STRIDE_16; // RULE_04
  assign fieldDone = (state_q == filter_loader_pkg::ST_WAIT_ACK) && memAck;
  assign isMaskField = (filter_list_count == '0); // RULE_07
  assign isPtrField = !isMaskField && (field_q == 3'd0);
  assign lastField = (field_q == `FL_FIELDS_PER_DESC - 3'd1);
  assign tblWrEn = fieldDone && !isMaskField && !isPtrField; // RULE_01
  assign tblPort = 2'(field_q - 3'd1); // RULE_06
  // address of the next field: the pointer as it stands after this edge
  assign ptrNext = fieldDone ? filter_list_pointer + stride :
    (filter_list_pointer_wr ? filter_list_pointer_in : filter_list_pointer);
  assign baseNext = upper_resource_base_wr ? upper_resource_base_in : upper_resource_base;

  always_comb begin
    state_d = state_q;
    case (state_q)
      filter_loader_pkg::ST_IDLE: begin
        if (load_filter_table_cmd) begin
          state_d = filter_loader_pkg::ST_WAIT_IDLE;
        end
      end
      filter_loader_pkg::ST_WAIT_IDLE: begin
        if (!txBusy && !rxBusy) begin
          state_d = filter_loader_pkg::ST_REQ; // RULE_12
        end
      end
      filter_loader_pkg::ST_REQ: state_d = filter_loader_pkg::ST_WAIT_ACK;
      filter_loader_pkg::ST_WAIT_ACK: begin
        if (memAck) begin
          state_d = isMaskField ? filter_loader_pkg::ST_FINISH : filter_loader_pkg::ST_REQ;
        end
      end
      filter_loader_pkg::ST_FINISH: state_d = filter_loader_pkg::ST_IDLE;
      default: state_d = filter_loader_pkg::ST_IDLE;
    endcase
  end

  // --------------------------------
  // sequencer
  // --------------------------------
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_q <= filter_loader_pkg::ST_IDLE;
      field_q <= 3'd0;
      entryPtr_q <= '0;
      memRdReq <= 1'b0;
      memAddr <= 32'h0;
    end else begin
      state_q <= state_d;
      memRdReq <= (state_d == filter_loader_pkg::ST_REQ);
      memAddr <= {baseNext, ptrNext}; // RULE_08
      if (state_q == filter_loader_pkg::ST_IDLE) begin
        field_q <= 3'd0;
      end else if (fieldDone) begin
        field_q <= lastField ? 3'd0 : field_q + 3'd1;
      end
      if (fieldDone && isPtrField) begin
        entryPtr_q <= fieldData[PW-1:0]; // RULE_06
      end
    end
  end

  // --------------------------------
  // software-visible registers
  // --------------------------------
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      filter_list_pointer <= 16'h0;
      filter_list_count <= '0;
      upper_resource_base <= 16'h0;
      load_filter_table_cmd <= 1'b0;
      filter_load_done_flag <= 1'b0;
    end else begin
      if (upper_resource_base_wr) begin
        upper_resource_base <= upper_resource_base_in;
      end
      if (fieldDone) begin
        filter_list_pointer <= filter_list_pointer + stride; // RULE_17 RULE_13
      end else if (filter_list_pointer_wr) begin
        filter_list_pointer <= filter_list_pointer_in;
      end
      if (fieldDone && !isMaskField && lastField) begin
        filter_list_count <= filter_list_count - 1'b1; // RULE_17 RULE_13
      end else if (filter_list_count_wr && state_q == filter_loader_pkg::ST_IDLE) begin
        filter_list_count <= filter_list_count_in[`FL_COUNT_W-1:0]; // RULE_09
      end
      if (state_q == filter_loader_pkg::ST_FINISH) begin
        load_filter_table_cmd <= 1'b0; // RULE_14
      end else if (load_filter_table_cmd_set) begin
        load_filter_table_cmd <= 1'b1;
      end
      if (state_q == filter_loader_pkg::ST_FINISH) begin
        filter_load_done_flag <= 1'b1; // RULE_14
      end else if (filter_load_done_flag_clr) begin
        filter_load_done_flag <= 1'b0;
      end
    end
  end

  // --------------------------------
  // filter table
  // --------------------------------
  filter_table_mem #(.ENTRIES(ENTRIES), .PW(PW)) tableMem (
    .clk(clk),
    .sys_rst(sys_rst),
    .wrEn(tblWrEn),
    .wrIdx(entryPtr_q),
    .wrPort(tblPort),
    .wrData(fieldData),
    .maskWrEn(fieldDone && isMaskField), // RULE_07
    .maskData(fieldData),
    .softReset(softReset), // RULE_02
    .rdIdx(tableRdIdx),
    .rdEntry(tableRdEntry),
    .enableMask(entryEnableMask) // RULE_16
  );
endmodule // address_filter_table_loader

// file: verif/filter_loader_monitor.sv
// Purpose: port checks of the filter loader
// Assumes: one clock
// Notes: bound below
module filter_loader_monitor (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic wideBus,
  input wire logic txBusy,
  input wire logic rxBusy,
  input wire logic softReset,
  input wire logic memRdReq,
  input wire logic [31:0] memAddr,
  input wire logic memAck,
  input wire logic load_filter_table_cmd,
  input wire logic filter_load_done_flag,
  input wire logic [15:0] filter_list_pointer,
  input wire logic [4:0] filter_list_count,
  input wire logic [15:0] upper_resource_base,
  input wire logic [47:0] tableRdEntry
);
  //---
  // checks
  //---
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  chk_addr_base: assert property (memRdReq |-> memAddr == {upper_resource_base, filter_list_pointer})
    else $error("addr");
  chk_busy_defer: assert property ((load_filter_table_cmd && (txBusy || rxBusy)) [*3] |-> !memRdReq)
    else $error("busy");
  chk_ptr_stride: assert property (memAck |=> filter_list_pointer ==
    $past(filter_list_pointer) + ($past(wideBus) ? 16'h0004 : 16'h0002)) else $error("stride");
  chk_field_spacing: assert property (memAck && filter_list_count != 5'h00 |=> memRdReq ##1 !memRdReq)
    else $error("spacing");
  chk_done_rise: assert property (memAck && filter_list_count == 5'h00 |-> ##[1:3]
    (filter_load_done_flag && !load_filter_table_cmd)) else $error("done");
  chk_count_zero: assert property ($fell(load_filter_table_cmd) |-> filter_list_count == 5'h00)
    else $error("count");
  chk_req_pulse: assert property (memRdReq |=> !memRdReq)
    else $error("pulse");
  chk_read_gate: assert property (!softReset |=> tableRdEntry == 48'h0)
    else $error("read");
endmodule // filter_loader_monitor

bind address_filter_table_loader filter_loader_monitor mon_u (.*);

// file: verif/sys_mem_model.sv
// Purpose: memory answering field reads
// Assumes: one read at a time
// Notes: upper half carries junk
module sys_mem_model (
  input wire logic clk,
  input wire logic memRdReq,
  input wire logic [31:0] memAddr,
  input wire logic wideBus,
  output logic memAck,
  output logic [31:0] memRdData
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] mem [64];
  initial begin
    memAck = 1'b0;
    memRdData = 32'h0;
    forever begin
      @(posedge clk);
      if (memRdReq) begin
        repeat (wideBus ? 3 : 0) @(posedge clk);
        memRdData <= {~mem[memAddr[7:1] >> wideBus], mem[memAddr[7:1] >> wideBus]};
        memAck <= 1'b1;
        @(posedge clk);
        memAck <= 1'b0;
        memRdData <= ~memRdData;
      end
    end
  end
endmodule // sys_mem_model

// file: verif/testbench.sv
// Purpose: loader bench
// Assumes: memory model answers
// Notes: drives on falling edges
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, sys_rst, wideBus, softReset, memRdReq, memAck, load_filter_table_cmd, filter_load_done_flag;
  logic [4:0] wr, filter_list_count;
  logic [1:0] busy;
  logic [3:0] tableRdIdx;
  logic [15:0] ptrIn, cntIn, filter_list_pointer, upper_resource_base, entryEnableMask;
  logic [31:0] memAddr, memRdData;
  logic [47:0] tableRdEntry;
  int error_cnt, cmp_count;
  address_filter_table_loader dut_u (.*, .upper_resource_base_wr(wr[0]), .upper_resource_base_in(16'h00c3),
    .filter_list_pointer_wr(wr[1]), .filter_list_pointer_in(ptrIn), .filter_list_count_wr(wr[2]),
    .filter_list_count_in(cntIn), .load_filter_table_cmd_set(wr[3]), .filter_load_done_flag_clr(wr[4]),
    .txBusy(busy[0]), .rxBusy(busy[1]));
  sys_mem_model mem_u (.*);
  task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %0t %h %h", $time, seen, exp);
    end
  endtask
  task automatic conclude;
    if (error_cnt == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic load(input logic [15:0] ptr, input logic [15:0] cnt, input logic [1:0] bz);
    int n;
    @(negedge clk);
    {ptrIn, cntIn, busy, wr} = {ptr, cnt, bz, 5'h17};
    @(negedge clk);
    wr = 5'h08;
    @(negedge clk);
    wr = 5'h00;
    chk(filter_load_done_flag, 1'b0);
    repeat (6) @(negedge clk);
    busy = 2'b00;
    for (n = 0; n < 300 && filter_load_done_flag !== 1'b1; n++) @(negedge clk);
    if (n == 300) begin
      error_cnt++;
      conclude();
    end
    chk(filter_list_count, 5'h00);
    chk(load_filter_table_cmd, 1'b0);
  endtask
  task automatic peek(input logic [3:0] idx, input logic [47:0] exp);
    @(negedge clk);
    tableRdIdx = idx;
    @(negedge clk);
    chk(tableRdEntry, exp);
  endtask
  task automatic scen_narrow;
    load(16'h0010, 16'h0002, 2'b01);
    chk(filter_list_pointer, 16'h0022);
    chk(upper_resource_base, 16'h00c3);
    chk(entryEnableMask, 16'ha510);
    peek(4'h5, 48'h0);
    softReset = 1'b1;
    peek(4'h5, 48'ha50ba50aa509);
    peek(4'h9, 48'ha50fa50ea50d);
  endtask
  task automatic scen_wide;
    softReset = 1'b0;
    wideBus = 1'b1;
    load(16'h0020, 16'hffe1, 2'b10);
    chk(filter_list_pointer, 16'h0034);
    chk(entryEnableMask, 16'h0009);
    softReset = 1'b1;
    peek(4'h5, 48'ha50ba50aa509);
  endtask
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial begin
    sys_rst = 1'b1;
    {wr, busy, ptrIn, cntIn, wideBus, softReset, tableRdIdx} = '0;
    for (int i = 0; i < 64; i++) mem_u.mem[i] = 16'ha500 + 16'(i);
    mem_u.mem[8] = 16'h0005;
    mem_u.mem[12] = 16'h0009;
    repeat (16) @(negedge clk);
    sys_rst = 1'b0;
    scen_narrow();
    scen_wide();
    conclude();
  end
endmodule // testbench
